// ==== verilog/ssr_pkg.sv ====
// package of timing constants and state encoding for the supply supervisor
package ssr_pkg;
	// ----------------------------------------
	// clock and timing figures
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 200; // system clock rate
	localparam int unsigned RESET_TIMEOUT_MS = 200; // nominal reset timeout period
	localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int unsigned WATCHDOG_TIMEOUT_MS = 1600; // nominal watchdog timeout
	localparam int unsigned WATCHDOG_TIMEOUT_CYC = WATCHDOG_TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int unsigned THRESHOLD_DELAY_US = 5; // longest supply-to-output delay
	localparam int unsigned THRESHOLD_DELAY_CYC = THRESHOLD_DELAY_US * CLK_MHZ;
	localparam int unsigned SUPPLY_GLITCH_NS = 30; // supply glitch width ignored
	localparam int unsigned SUPPLY_GLITCH_CYC = (SUPPLY_GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned MANUAL_GLITCH_NS = 100; // manual reset glitch width ignored
	localparam int unsigned MANUAL_GLITCH_CYC = (MANUAL_GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned MANUAL_DELAY_US = 1; // longest manual-to-output delay
	localparam int unsigned MANUAL_DELAY_CYC = MANUAL_DELAY_US * CLK_MHZ;
	localparam int unsigned FILT_W = 8; // width of glitch filter counters
	localparam int unsigned CNT_W = 32; // width of long timers
	// ----------------------------------------
	// supervisor states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00, // reset source active
		ST_TIMEOUT = 2'b01, // stretching after source release
		ST_RUN = 2'b11 // reset released, watchdog running
	} ssr_state_t;
endpackage : ssr_pkg

// ==== verilog/ssr_supervisor.sv ====
// supply supervisor with manual reset, reset pin input and watchdog
`timescale 1ns/10ps
// Summary of operation
// - hold reset through supply low, then timeout
// - release open-drain outputs after timeout expires
// - assert reset within 5 us of supply drop
// - ignore supply dips up to 30 ns
// - falling edge on reset pin starts timeout
// - reset pin pulse gives full 200 ms reset
// - low manual reset input causes reset
// - hold reset while manual low, plus timeout
// - reject manual pulses below 100 ns
// - manual reset reaches outputs within 1 us
// - reset blocks and aborts memory transactions
// - no new write in reset; finish current
// - write-protect high blocks all memory writes
// - no line activity for 1.6 s resets
// - monitored line chosen at build time
// - any line transition clears watchdog counter
// - watchdog held cleared while reset asserted
module ssr_supervisor #(
	parameter int unsigned RESET_CYC = ssr_pkg::RESET_TIMEOUT_CYC, // reset stretch length
	parameter int unsigned WDOG_CYC = ssr_pkg::WATCHDOG_TIMEOUT_CYC, // watchdog length
	parameter bit WDOG_ON_KICK = 1'b1 // 1: kick input, 0: serial data line
) (
	input wire logic clk_i, // 200 MHz internal oscillator
	input wire logic sys_rst_i, // async reset, active high
	input wire logic supply_ok_i, // comparator: supply above threshold
	input wire logic manual_reset_n_input_i, // manual reset, active low
	input wire logic reset_pin_n_i, // level seen on the low reset pin
	input wire logic watchdog_kick_input_i, // dedicated watchdog line
	input wire logic serial_data_i, // serial data line
	input wire logic write_protect_i, // write protect, active high
	input wire logic mem_write_req_i, // memory core wants to start a write
	input wire logic mem_write_busy_i, // internal write cycle running
	output logic reset_pin_n_o, // low reset pin output value (always 0)
	output logic reset_pin_n_oe_o, // drive enable of low reset pin
	output logic reset_hi_o, // high reset pin output value (always 1)
	output logic reset_hi_oe_o, // drive enable of high reset pin
	output logic mem_enable_o, // memory and serial interface allowed
	output logic mem_write_start_o // start a nonvolatile write cycle
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	ssr_pkg::ssr_state_t state_q; // supervisor state
	logic [ssr_pkg::FILT_W-1:0] sup_cnt_q; // supply low duration
	logic sup_low_q; // filtered supply low
	logic [ssr_pkg::FILT_W-1:0] man_cnt_q; // manual low duration
	logic man_low_q; // filtered manual low
	logic pin_prev_q; // previous reset pin level
	logic pin_fall; // falling edge seen on reset pin
	logic [ssr_pkg::CNT_W-1:0] tmo_cnt_q; // reset timeout counter
	logic [ssr_pkg::CNT_W-1:0] wd_cnt_q; // watchdog counter
	logic wd_prev_q; // previous monitored level
	logic wd_line; // selected monitored line
	logic wd_fire_q; // watchdog expired pulse
	logic in_reset; // reset condition from state
	logic hold_src; // level reset sources
	logic restart; // event restarting timeout
	logic [ssr_pkg::FILT_W-1:0] man_run_q; // checker: consecutive manual low cycles

	// reset is driven while any source is live or the stretch runs
	function automatic logic rst_active(input logic lvl, input logic edg, input logic st);
		rst_active = lvl | edg | st;
	endfunction : rst_active

	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	// supply filter: dips no longer than glitch width are ignored
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sup_cnt_q <= '0;
			sup_low_q <= 1'b1;
		end else if (supply_ok_i) begin // supply good, clear count
			sup_cnt_q <= '0;
			sup_low_q <= 1'b0;
		end else if (sup_cnt_q >= ssr_pkg::FILT_W'(ssr_pkg::SUPPLY_GLITCH_CYC)) begin
			sup_low_q <= 1'b1;
		end else begin
			sup_cnt_q <= sup_cnt_q + 1'b1;
		end
	end

	// manual filter: pulses shorter than glitch width rejected
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			man_cnt_q <= '0;
			man_low_q <= 1'b0;
		end else if (manual_reset_n_input_i) begin // released
			man_cnt_q <= '0;
			man_low_q <= 1'b0;
		end else if (man_cnt_q >= ssr_pkg::FILT_W'(ssr_pkg::MANUAL_GLITCH_CYC)) begin
			man_low_q <= 1'b1;
		end else begin
			man_cnt_q <= man_cnt_q + 1'b1;
		end
	end

	// reset pin edge detect: only a high-to-low edge counts
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_prev_q <= 1'b0; // pin is held low in reset, so no false edge after it
		end else begin
			pin_prev_q <= reset_pin_n_i;
		end
	end
	assign pin_fall = pin_prev_q & ~reset_pin_n_i;

	// ----------------------------------------
	// reset state machine
	// ----------------------------------------
	assign hold_src = sup_low_q | man_low_q;
	assign restart = pin_fall | wd_fire_q;
	assign in_reset = (state_q != ssr_pkg::ST_RUN);

	// state and timeout counter; any new source restarts the stretch
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= ssr_pkg::ST_HOLD;
			tmo_cnt_q <= '0;
		end else if (hold_src) begin // level source active
			state_q <= ssr_pkg::ST_HOLD;
			tmo_cnt_q <= '0;
		end else if (restart) begin // edge sources start a full stretch
			state_q <= ssr_pkg::ST_TIMEOUT;
			tmo_cnt_q <= '0;
		end else begin
			case (state_q)
				ssr_pkg::ST_HOLD: begin // source gone, begin stretch
					state_q <= ssr_pkg::ST_TIMEOUT;
					tmo_cnt_q <= '0;
				end
				ssr_pkg::ST_TIMEOUT: begin // count out the period
					if (tmo_cnt_q >= RESET_CYC - 1) begin
						state_q <= ssr_pkg::ST_RUN;
					end else begin
						tmo_cnt_q <= tmo_cnt_q + 1'b1;
					end
				end
				ssr_pkg::ST_RUN: begin // normal running
					tmo_cnt_q <= '0;
				end
				default: begin
					state_q <= ssr_pkg::ST_HOLD;
				end
			endcase
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	assign wd_line = WDOG_ON_KICK ? watchdog_kick_input_i : serial_data_i;

	// counter cleared on any transition, held clear in reset
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wd_prev_q <= 1'b0;
			wd_cnt_q <= '0;
			wd_fire_q <= 1'b0;
		end else begin
			wd_prev_q <= wd_line;
			wd_fire_q <= 1'b0;
			if (in_reset || hold_src) begin
				wd_cnt_q <= '0;
			end else if (wd_line != wd_prev_q) begin
				wd_cnt_q <= '0;
			end else if (wd_cnt_q >= WDOG_CYC - 1) begin
				wd_fire_q <= 1'b1;
				wd_cnt_q <= '0;
			end else begin
				wd_cnt_q <= wd_cnt_q + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// both polarities follow the one state; released means not driven
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reset_pin_n_o <= 1'b0;
			reset_pin_n_oe_o <= 1'b1;
			reset_hi_o <= 1'b1;
			reset_hi_oe_o <= 1'b1;
		end else begin
			reset_pin_n_o <= 1'b0;
			reset_hi_o <= 1'b1;
			reset_pin_n_oe_o <= rst_active(hold_src, restart, in_reset);
			reset_hi_oe_o <= rst_active(hold_src, restart, in_reset);
		end
	end

	// memory gating: none in reset, writes blocked by protect
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem_enable_o <= 1'b0;
			mem_write_start_o <= 1'b0;
		end else begin
			mem_enable_o <= ~rst_active(hold_src, restart, in_reset);
			// a running write is left alone; only new starts are gated
			mem_write_start_o <= mem_write_req_i & ~mem_write_busy_i & ~write_protect_i
				& ~rst_active(hold_src, restart, in_reset);
		end
	end

	// ----------------------------------------
	// checker helper logic
	// ----------------------------------------
	// counts consecutive low cycles of the manual input, saturating;
	// kept apart from the filter so the delay check does not lean on it
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			man_run_q <= '0;
		end else if (manual_reset_n_input_i) begin // input high, restart count
			man_run_q <= '0;
		end else if (man_run_q != '1) begin // still low, count up
			man_run_q <= man_run_q + 1'b1;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	out_polarity_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reset_pin_n_oe_o == reset_hi_oe_o) else $error("reset polarities disagree");
	supply_assert_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(supply_ok_i) ##1 !supply_ok_i [*8] |-> ##[0:8] reset_pin_n_oe_o)
		else $error("supply drop did not assert reset");
	supply_glitch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!in_reset && !hold_src && !restart && supply_ok_i ##1 !supply_ok_i ##1 supply_ok_i
		|=> !reset_pin_n_oe_o) else $error("supply glitch caused reset");
	// a low held past the glitch width must reach the outputs within 1 us
	manual_assert_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		man_run_q == ssr_pkg::FILT_W'(ssr_pkg::MANUAL_GLITCH_CYC + 1) |-> ##[0:200] reset_hi_oe_o)
		else $error("manual reset not applied in time");
	manual_glitch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!in_reset && !hold_src && !restart && supply_ok_i && manual_reset_n_input_i
		##1 !manual_reset_n_input_i ##1 manual_reset_n_input_i && supply_ok_i |=> !reset_hi_oe_o)
		else $error("short manual pulse caused reset");
	pin_edge_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		pin_fall |=> state_q == ssr_pkg::ST_TIMEOUT || state_q == ssr_pkg::ST_HOLD)
		else $error("reset pin edge ignored");
	wdog_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		in_reset |=> wd_cnt_q == '0) else $error("watchdog counted in reset");
	wdog_kick_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!in_reset && !hold_src && wd_line != wd_prev_q |=> wd_cnt_q == '0)
		else $error("transition did not clear watchdog");
	mem_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reset_hi_oe_o |-> !mem_enable_o) else $error("memory enabled in reset");
	wp_block_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$past(write_protect_i) |-> !mem_write_start_o) else $error("write while protected");
	release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_q == ssr_pkg::ST_RUN && !hold_src && !restart |=> !reset_pin_n_oe_o)
		else $error("outputs not released");
	// the assertions below pin down the level holds, the stretch, the watchdog, the gating and the pin levels
	// a filtered manual low keeps the outputs driven
	manual_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		man_low_q |=> reset_hi_oe_o) else $error("manual low did not hold reset");
	// a filtered supply low keeps the outputs driven
	supply_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		sup_low_q |=> reset_pin_n_oe_o) else $error("supply low did not hold reset");
	// the stretch keeps the outputs driven until the counter runs out
	stretch_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_q == ssr_pkg::ST_TIMEOUT && tmo_cnt_q < RESET_CYC - 1 |=> reset_pin_n_oe_o)
		else $error("outputs released before timeout");
	// the stretch ends exactly when the counter reaches its last value
	stretch_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_q == ssr_pkg::ST_TIMEOUT && !hold_src && !restart && tmo_cnt_q == RESET_CYC - 1
		|=> state_q == ssr_pkg::ST_RUN) else $error("stretch did not end on time");
	// a pin edge outside a level source restarts the stretch from zero
	pin_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		pin_fall && !hold_src |=> state_q == ssr_pkg::ST_TIMEOUT && tmo_cnt_q == '0 && reset_pin_n_oe_o)
		else $error("pin edge did not restart timeout");
	// the watchdog fires only after the full quiet span
	wdog_span_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wd_fire_q |-> $past(wd_cnt_q) == WDOG_CYC - 1) else $error("watchdog fired early");
	// a watchdog expiry drives the outputs on the next cycle
	wdog_reset_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wd_fire_q |=> reset_pin_n_oe_o) else $error("watchdog expiry did not reset");
	// no new write is started while reset is driven
	write_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		reset_pin_n_oe_o |-> !mem_write_start_o) else $error("write started in reset");
	// once the outputs are let go the memory is open again
	mem_open_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!reset_pin_n_oe_o |-> mem_enable_o) else $error("memory closed outside reset");
	// driven values of both pins are fixed; only the enables move
	pin_level_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!reset_pin_n_o && reset_hi_o) else $error("reset pin drive value wrong");
	cov_release_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(reset_hi_oe_o));
	cov_manual_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) man_low_q);
	cov_wdog_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) wd_fire_q);
	cov_pin_c: cover property (@(posedge clk_i) disable iff (sys_rst_i) pin_fall && !in_reset);
	// a one-cycle supply dip seen while running
	cov_glitch_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		!in_reset && supply_ok_i ##1 !supply_ok_i ##1 supply_ok_i);
endmodule : ssr_supervisor

// ==== sim/ssr_host_model.sv ====
// host model: watches the reset pin, kicks the watchdog, may pull the pin low
`timescale 1ns/10ps
module ssr_host_model (
	input wire logic clk_i, // system clock
	input wire logic kick_en_i, // keep kicking the watchdog
	input wire logic pull_low_i, // push the reset pin low from outside
	input wire logic reset_oe_i, // device pulls the reset pin low
	output logic kick_o, // watchdog line
	output logic reset_pin_n_o // resolved reset pin level
);
	logic [5:0] div_q = 6'h00; // kick interval counter
	logic kick_q = 1'b0; // kick line state
	// ----------------------------------------
	// kick generator
	// ----------------------------------------
	// toggles every 50 cycles, well inside the watchdog span
	always_ff @(posedge clk_i) begin
		if (kick_en_i && div_q == 6'h31) begin
			div_q <= 6'h00;
			kick_q <= ~kick_q;
		end else begin
			div_q <= (div_q == 6'h31) ? 6'h00 : div_q + 6'h01;
		end
	end
	assign kick_o = kick_q;
	// open drain with pull-up: low whenever anyone drives it
	assign reset_pin_n_o = ~(reset_oe_i | pull_low_i);
endmodule : ssr_host_model

// ==== sim/ssr_supervisor_bench.sv ====
// self-checking testbench for the supply supervisor
`timescale 1ns/10ps
module ssr_supervisor_bench;
	localparam int unsigned RC = 50; // shortened reset stretch
	localparam int unsigned WC = 200; // shortened watchdog span
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic supply_ok_i = 1'b0; // comparator level
	logic manual_n = 1'b1; // manual reset, active low
	logic pull_low = 1'b0; // host pulls reset pin
	logic kick_en = 1'b1; // host kicks watchdog
	logic wp = 1'b0; // write protect
	logic req = 1'b0; // write request
	logic busy = 1'b0; // write cycle running
	logic pin_o, pin_oe, hi_o, hi_oe, mem_en, wr_start, kick, pin_lvl;
	int mismatches = 0;
	int cmp_count = 0;
	ssr_supervisor #(.RESET_CYC(RC), .WDOG_CYC(WC), .WDOG_ON_KICK(1'b1)) uut (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i), .manual_reset_n_input_i(manual_n),
		.reset_pin_n_i(pin_lvl), .watchdog_kick_input_i(kick), .serial_data_i(1'b1),
		.write_protect_i(wp), .mem_write_req_i(req), .mem_write_busy_i(busy), .reset_pin_n_o(pin_o),
		.reset_pin_n_oe_o(pin_oe), .reset_hi_o(hi_o), .reset_hi_oe_o(hi_oe), .mem_enable_o(mem_en),
		.mem_write_start_o(wr_start));
	ssr_host_model host (.clk_i(clk_i), .kick_en_i(kick_en), .pull_low_i(pull_low),
		.reset_oe_i(pin_oe), .kick_o(kick), .reset_pin_n_o(pin_lvl));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic chk(input string name, input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	// source just removed: outputs hold for the stretch, then let go
	task automatic expect_release();
		step(RC - 5);
		chk("oe held", pin_oe, 1'b1);
		chk("pin value", pin_o, 1'b0);
		chk("hi value", hi_o, 1'b1);
		step(15);
		chk("oe released", pin_oe, 1'b0);
		chk("hi oe same", hi_oe, 1'b0);
		chk("mem on", mem_en, 1'b1);
	endtask : expect_release
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_supply();
		supply_ok_i = 1'b0;
		step(1);
		supply_ok_i = 1'b1;
		step(3);
		chk("narrow dip", pin_oe, 1'b0);
		supply_ok_i = 1'b0;
		step(5);
		supply_ok_i = 1'b1;
		step(10);
		chk("dip ignored", pin_oe, 1'b0);
		supply_ok_i = 1'b0;
		step(10);
		chk("drop asserts", pin_oe, 1'b1);
		chk("mem off", mem_en, 1'b0);
		supply_ok_i = 1'b1;
		expect_release();
	endtask : t_supply
	task automatic t_manual();
		manual_n = 1'b0;
		step(1);
		manual_n = 1'b1;
		step(3);
		chk("narrow pulse", pin_oe, 1'b0);
		manual_n = 1'b0;
		step(15);
		manual_n = 1'b1;
		step(30);
		chk("short pulse", pin_oe, 1'b0);
		manual_n = 1'b0;
		step(25);
		chk("manual asserts", pin_oe, 1'b1);
		step(2 * RC);
		chk("held while low", pin_oe, 1'b1);
		manual_n = 1'b1;
		expect_release();
	endtask : t_manual
	task automatic t_pin();
		pull_low = 1'b1;
		step(3);
		chk("pin edge", pin_oe, 1'b1);
		pull_low = 1'b0;
		expect_release();
	endtask : t_pin
	task automatic t_wdog();
		int n;
		step(3 * WC);
		chk("kicks keep run", pin_oe, 1'b0);
		kick_en = 1'b0;
		step(WC - 60);
		chk("no early fire", pin_oe, 1'b0);
		n = 0;
		while (pin_oe !== 1'b1 && n < 150) begin
			step(1);
			n++;
		end
		chk("watchdog fires", pin_oe, 1'b1);
		step(RC + 20);
		chk("counter cleared", pin_oe, 1'b0);
		kick_en = 1'b1;
	endtask : t_wdog
	task automatic t_mem();
		req = 1'b1; // only after the stretch has ended
		step(3);
		chk("write start", wr_start, 1'b1);
		wp = 1'b1;
		step(3);
		chk("protected", wr_start, 1'b0);
		wp = 1'b0;
		busy = 1'b1;
		step(3);
		chk("busy no start", wr_start, 1'b0);
		busy = 1'b0;
		supply_ok_i = 1'b0;
		step(12);
		chk("no start in reset", wr_start, 1'b0);
		chk("mem gated", mem_en, 1'b0);
		req = 1'b0;
		supply_ok_i = 1'b1;
		expect_release();
	endtask : t_mem
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		step(10);
		sys_rst_i = 1'b0;
		step(5);
		chk("oe at power-up", pin_oe, 1'b1);
		supply_ok_i = 1'b1;
		expect_release();
		t_supply();
		t_manual();
		t_pin();
		t_wdog();
		t_mem();
		wrap_up();
	end
	initial begin
		#20000;
		mismatches++;
		wrap_up();
	end
endmodule : ssr_supervisor_bench
